// [hdl/pin_function_config.sv]
`timescale 1ns/10ps
`include "pin_function_params.svh"
module pin_function_config
  import pin_function_pkg::*;
#(
  parameter int PINS = 5,
  parameter int LAMP_COUNT = (`CLK_HZ / 1000) * `LAMP_STRETCH_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic usb_reset,
  // Configuration memory read port, word per cycle, one-cycle latency
  output logic [3:0] nvm_addr,
  output logic nvm_read,
  input wire logic [7:0] nvm_data,
  input wire logic nvm_blank,
  // USB state from the protocol engine
  input wire logic enumerated,
  input wire logic suspended,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic tx_shifting,
  output logic remote_wakeup,
  output logic [15:0] usb_release,
  output logic config_ready,
  // Serial and modem lines, core side (true polarity)
  input wire logic [7:0] core_out,
  output logic [7:0] core_in,
  // Serial and modem pins: 0 txd,1 rxd,2 rts,3 cts,4 dtr,5 dsr,6 dcd,7 ring
  input wire logic [7:0] serial_pin_in,
  output logic [7:0] serial_pin_out,
  output logic [7:0] serial_pin_oe_n,
  // Configurable pins
  output logic [PINS-1:0] configurable_pin_out,
  output logic [PINS-1:0] configurable_pin_oe_n
);
  // Directions: txd, rts, dtr are driven as outputs; the other lines are driven only by the pull-down
  localparam logic [7:0] OUT_MASK = 8'h15;
  localparam int CLK_DIV_HALF = `CLK_HZ / (2 * `CLKOUT_HZ);

  if (PINS != 5)
  begin
    $error("pin_function_config: five configurable pins are supported");
  end
  if (LAMP_COUNT < 2)
  begin
    $error("pin_function_config: LAMP_COUNT must be at least 2");
  end

  // ------------------------------------------------------------
  // Configuration load
  // ------------------------------------------------------------
  cfg_state_t state;
  logic [3:0] word;
  logic [63:0] image;
  logic capture;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= ST_RESET;
    else if (usb_reset)
      state <= ST_RESET;
    else
    begin
      unique case (state)
        ST_RESET: state <= ST_LOAD;
        ST_LOAD: state <= (word == `IMG_WORDS) ? ST_RUN : ST_LOAD;
        ST_RUN: state <= ST_RUN;
        default: state <= ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      word <= 4'h0;
    else if (state != ST_LOAD)
      word <= 4'h0;
    else if (word != `IMG_WORDS)
      word <= word + 4'h1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      capture <= 1'b0;
    else
      capture <= nvm_read;
  end

  // Blank memory falls back to the factory image
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      image <= 64'(`IMG_DEFAULT);
    else if (capture && nvm_blank)
      image <= 64'(`IMG_DEFAULT);
    else if (capture)
      image <= {nvm_data, image[63:8]};
  end

  assign nvm_read = (state == ST_LOAD) && (word != `IMG_WORDS);
  assign nvm_addr = word;
  assign config_ready = (state == ST_RUN);

  logic pulldown_en;
  logic wakeup_en;
  logic [7:0] invert;
  assign pulldown_en = image[`IMG_OPT_PULLDOWN];
  assign wakeup_en = image[`IMG_OPT_WAKEUP];
  assign invert = image[`IMG_INV_LSB +: 8];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      usb_release <= `USB_RELEASE;
    else
      usb_release <= `USB_RELEASE;
  end

  // ------------------------------------------------------------
  // Activity lamps and clock output
  // ------------------------------------------------------------
  logic tx_lamp;
  logic rx_lamp;
  logic both_lamp;

  lamp_one_shot #(.COUNT(LAMP_COUNT)) u_tx_shot (
    .clk(clk), .reset_n(reset_n), .trigger(tx_busy), .active(tx_lamp));
  lamp_one_shot #(.COUNT(LAMP_COUNT)) u_rx_shot (
    .clk(clk), .reset_n(reset_n), .trigger(rx_busy), .active(rx_lamp));
  lamp_one_shot #(.COUNT(LAMP_COUNT)) u_both_shot (
    .clk(clk), .reset_n(reset_n), .trigger(tx_busy || rx_busy), .active(both_lamp));

  // 50 MHz cannot divide evenly to 12 MHz; nearest even divider is used
  logic [3:0] div;
  logic clk_out;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      div <= 4'h0;
    else if (div >= 4'(CLK_DIV_HALF - 1))
      div <= 4'h0;
    else
      div <= div + 4'h1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      clk_out <= 1'b0;
    else if (div >= 4'(CLK_DIV_HALF - 1))
      clk_out <= ~clk_out;
  end

  // ------------------------------------------------------------
  // Pin function mux
  // ------------------------------------------------------------
  logic power_en_n;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      power_en_n <= 1'b1;
    else
      power_en_n <= !(enumerated && !suspended);
  end

  function automatic logic [1:0] pin_drive(input logic [2:0] sel);
    // Returns {oe_n, value}
    unique case (sel)
      `SEL_TX_LAMP: pin_drive = tx_lamp ? 2'b00 : 2'b11;
      `SEL_RX_LAMP: pin_drive = rx_lamp ? 2'b00 : 2'b11;
      `SEL_COMBINED: pin_drive = both_lamp ? 2'b00 : 2'b11;
      `SEL_DRIVER_EN: pin_drive = {1'b0, tx_shifting};
      `SEL_POWER_EN: pin_drive = {1'b0, power_en_n};
      `SEL_SUSPEND: pin_drive = {1'b0, !suspended};
      `SEL_CLOCK_OUT: pin_drive = {1'b0, clk_out};
      default: pin_drive = 2'b11;
    endcase
  endfunction

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      configurable_pin_out <= '1;
      configurable_pin_oe_n <= '1;
    end
    else
    begin
      for (int p = 0; p < PINS; p++)
      begin
        logic [1:0] d;
        d = config_ready ? pin_drive(image[p*`IMG_SEL_W +: `IMG_SEL_W]) : 2'b11;
        configurable_pin_oe_n[p] <= d[1];
        configurable_pin_out[p] <= d[0];
      end
    end
  end

  // ------------------------------------------------------------
  // Serial lines: inversion, suspend pull-down, wakeup
  // ------------------------------------------------------------
  logic pull_low;
  assign pull_low = pulldown_en && power_en_n;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serial_pin_out <= '1;
      serial_pin_oe_n <= '1;
    end
    else if (!config_ready)
    begin
      serial_pin_out <= '1;
      serial_pin_oe_n <= '1;
    end
    else if (pull_low)
    begin
      serial_pin_out <= '0;
      serial_pin_oe_n <= '0;
    end
    else
    begin
      serial_pin_out <= core_out ^ invert;
      serial_pin_oe_n <= ~OUT_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      core_in <= '1;
    else
      core_in <= serial_pin_in ^ invert;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      remote_wakeup <= 1'b0;
    else
      remote_wakeup <= wakeup_en && suspended && !core_in[7];
  end

  a_susp_indicator: assert property (@(posedge clk) disable iff (!reset_n)
    config_ready && image[14:12] == `SEL_SUSPEND && suspended
    |=> !configurable_pin_out[4] && !configurable_pin_oe_n[4])
    else $error("suspend indicator not low");
  a_power_enable: assert property (@(posedge clk) disable iff (!reset_n)
    suspended |=> power_en_n)
    else $error("power enable not high in suspend");
  a_reset_release: assert property (@(posedge clk) disable iff (!reset_n)
    !config_ready |=> serial_pin_oe_n == 8'hff)
    else $error("serial pins driven before config");
  a_load_first: assert property (@(posedge clk) disable iff (!reset_n)
    usb_reset |=> !config_ready ##1 !config_ready)
    else $error("pins active before image load");
  a_pull_down: assert property (@(posedge clk) disable iff (!reset_n)
    config_ready && pull_low |=> serial_pin_out == 8'h00)
    else $error("pull-down not applied");
  a_wake_ring: assert property (@(posedge clk) disable iff (!reset_n)
    wakeup_en && suspended && $past(suspended) && !core_in[7] |=> remote_wakeup)
    else $error("wakeup missed");
  a_release_code: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(config_ready) |-> usb_release == 16'h0200)
    else $error("wrong release code");
  a_lamp_idle: assert property (@(posedge clk) disable iff (!reset_n)
    config_ready && image[2:0] == `SEL_TX_LAMP && !tx_lamp
    |=> configurable_pin_oe_n[0])
    else $error("idle tx lamp not floating");
  a_driver_enable: assert property (@(posedge clk) disable iff (!reset_n)
    config_ready && image[8:6] == `SEL_DRIVER_EN
    |=> configurable_pin_out[2] == $past(tx_shifting))
    else $error("driver enable mismatch");

  c_load_done: cover property (@(posedge clk) $rose(config_ready));
  c_suspend: cover property (@(posedge clk) config_ready && suspended);
  c_wakeup: cover property (@(posedge clk) remote_wakeup);
endmodule

// [hdl/pin_function_params.svh]
`ifndef PIN_FUNCTION_PARAMS_SVH
`define PIN_FUNCTION_PARAMS_SVH
// Pin function select codes
`define SEL_TX_LAMP 3'h0
`define SEL_RX_LAMP 3'h1
`define SEL_DRIVER_EN 3'h2
`define SEL_POWER_EN 3'h3
`define SEL_SUSPEND 3'h4
`define SEL_COMBINED 3'h5
`define SEL_CLOCK_OUT 3'h6
// Image layout: 5 pin selects of 3 bits, then options
`define IMG_WORDS 4'h8
`define IMG_SEL_W 3
`define IMG_OPT_PULLDOWN 15
`define IMG_OPT_WAKEUP 16
`define IMG_INV_LSB 17
`define IMG_USB_VER_LSB 25
// Factory defaults: pin4..pin0 = 4,3,2,1,0, wakeup on, pulldown off, no inversion,
// release code 0200 in the top field
`define IMG_DEFAULT 41'h004_0001_4688
`define USB_RELEASE 16'h0200
// Timing
`define CLK_HZ 50000000
`define LAMP_STRETCH_MS 50
`define CLKOUT_HZ 12000000
`endif

// [hdl/pin_function_pkg.sv]
package pin_function_pkg;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } cfg_state_t;
endpackage

// [hdl/lamp_one_shot.sv]
`timescale 1ns/10ps
`include "pin_function_params.svh"
module lamp_one_shot #(
  parameter int COUNT = 2500000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Trigger and stretched output
  input wire logic trigger,
  output logic active
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] remain;

  // Two or more, so that a single-cycle trigger still holds the lamp past its own cycle
  if (COUNT < 2)
  begin
    $error("lamp_one_shot: COUNT must be at least 2");
  end

  // Retrigger restarts the timer so busy traffic keeps the lamp lit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      remain <= '0;
    else if (trigger)
      remain <= W'(COUNT);
    else if (remain != '0)
      remain <= remain - 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      active <= 1'b0;
    else
      active <= trigger || (remain > W'(1));
  end

  a_stretch_hold: assert property (@(posedge clk) disable iff (!reset_n)
    trigger |=> active[*2])
    else $error("lamp not held after trigger");
endmodule

// [tb/serial_far_end.sv]
`timescale 1ns/10ps
module serial_far_end (
  // Clock
  input wire logic clk,
  // Configuration memory
  input wire logic [3:0] nvm_addr,
  input wire logic nvm_read,
  output logic [7:0] nvm_data,
  output logic nvm_blank,
  input wire logic [63:0] image,
  input wire logic blank,
  // Serial pins
  input wire logic [7:0] serial_pin_out,
  input wire logic [7:0] serial_pin_oe_n,
  output logic [7:0] serial_pin_in,
  input wire logic [7:0] far_drive,
  input wire logic echo_kill
);
  logic [7:0] far;
  // Outside a read the data flips, so a late capture cannot match by luck
  always @(posedge clk)
  begin
    if (nvm_read)
    begin
      nvm_data <= image[{nvm_addr, 3'h0} +: 8];
      nvm_blank <= blank;
    end
    else
    begin
      nvm_data <= ~nvm_data;
      nvm_blank <= ~nvm_blank;
    end
  end
  // Receive is forced idle while the line driver is on
  assign far = {far_drive[7:2], far_drive[1] | echo_kill, far_drive[0]};
  // Far side drives only the input lines; released lines float up
  assign serial_pin_in = (~serial_pin_oe_n & serial_pin_out)
    | (serial_pin_oe_n & ((far & 8'hea) | 8'h15));
endmodule

// [tb/configurable_pin_pin_function_config_test.sv]
`timescale 1ns/10ps
`include "pin_function_params.svh"
module configurable_pin_pin_function_config_test;
  localparam int LAMP = 4;
  logic clk = 0, reset_n = 0, usb_reset = 0, nvm_read, nvm_blank, blank = 1;
  logic enumerated = 0, suspended = 0, tx_busy = 0, rx_busy = 0, tx_shifting = 0;
  logic remote_wakeup, config_ready, pd, wk;
  logic [3:0] nvm_addr;
  logic [7:0] nvm_data, core_in, serial_pin_in, serial_pin_out, serial_pin_oe_n;
  logic [7:0] core_out = 0, far_drive = 8'hff, inv;
  logic [15:0] usb_release;
  logic [4:0] cfg_out, cfg_oe_n;
  logic [63:0] image = 0;
  logic [2:0] sel [5];
  int n_errors = 0, n_compared = 0, reads = 0;

  pin_function_config #(.LAMP_COUNT(LAMP)) uut (.clk(clk), .reset_n(reset_n),
    .usb_reset(usb_reset), .nvm_addr(nvm_addr), .nvm_read(nvm_read), .nvm_data(nvm_data),
    .nvm_blank(nvm_blank), .enumerated(enumerated), .suspended(suspended),
    .tx_busy(tx_busy), .rx_busy(rx_busy), .tx_shifting(tx_shifting),
    .remote_wakeup(remote_wakeup), .usb_release(usb_release), .config_ready(config_ready),
    .core_out(core_out), .core_in(core_in), .serial_pin_in(serial_pin_in),
    .serial_pin_out(serial_pin_out), .serial_pin_oe_n(serial_pin_oe_n),
    .configurable_pin_out(cfg_out), .configurable_pin_oe_n(cfg_oe_n));
  serial_far_end far_end (.clk(clk), .nvm_addr(nvm_addr), .nvm_read(nvm_read),
    .nvm_data(nvm_data), .nvm_blank(nvm_blank), .image(image), .blank(blank),
    .serial_pin_out(serial_pin_out), .serial_pin_oe_n(serial_pin_oe_n),
    .serial_pin_in(serial_pin_in), .far_drive(far_drive), .echo_kill(tx_shifting));

  always #10 clk = ~clk;
  always @(posedge clk) if (nvm_read === 1'b1) reads = reads + 1;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task wait_ready;
    for (int i = 0; i < 40 && config_ready !== 1'b1; i++) cyc(1);
    if (config_ready !== 1'b1)
    begin
      n_errors++;
      finish_test;
    end
    check(16'(reads), 16'd8);
    cyc(1);
  endtask
  task compare_all;
    logic eo, ev, pdn;
    logic [7:0] lvl;
    pdn = pd && !(enumerated && !suspended);
    for (int i = 0; i < 5; i++)
    begin
      case (sel[i])
        `SEL_TX_LAMP: {eo, ev} = {!tx_busy, 1'b0};
        `SEL_RX_LAMP: {eo, ev} = {!rx_busy, 1'b0};
        `SEL_COMBINED: {eo, ev} = {!(tx_busy || rx_busy), 1'b0};
        `SEL_DRIVER_EN: {eo, ev} = {1'b0, tx_shifting};
        `SEL_POWER_EN: {eo, ev} = {1'b0, !(enumerated && !suspended)};
        default: {eo, ev} = {1'b0, !suspended};
      endcase
      if (sel[i] != `SEL_CLOCK_OUT)
        check({cfg_oe_n[i], !eo && cfg_out[i]}, {eo, !eo && ev});
    end
    if (pdn)
      check({serial_pin_oe_n, serial_pin_out}, 16'h0);
    else
      check({serial_pin_oe_n, serial_pin_out & 8'h15}, {~8'h15, (core_out ^ inv) & 8'h15});
    lvl = pdn ? 8'h0 : ({far_drive[7:2], far_drive[1] | tx_shifting, far_drive[0]} & 8'hea)
      | ((core_out ^ inv) & 8'h15);
    check(core_in, lvl ^ inv);
    if (!pdn)
      check(remote_wakeup, wk && suspended && !(lvl[7] ^ inv[7]));
  endtask
  task stim;
    int c;
    logic p;
    {enumerated, suspended, tx_busy, rx_busy, tx_shifting} = 5'($urandom);
    far_drive = 8'($urandom);
    core_out = 8'($urandom);
    cyc(LAMP + 6);
    compare_all;
    for (int i = 0; i < 5; i++)
    begin
      if (sel[i] == `SEL_CLOCK_OUT)
      begin
        c = 0;
        for (int k = 0; k < 16; k++)
        begin
          p = cfg_out[i];
          cyc(1);
          if (p === 1'b0 && cfg_out[i] === 1'b1) c++;
        end
        check({cfg_oe_n[i], 15'(c)}, 16'd4);
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(44191));
    sel = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    {pd, wk, inv} = {1'b0, 1'b1, 8'h0};
    cyc(5);
    check({cfg_oe_n, serial_pin_oe_n}, 13'h1fff);
    reads = 0;
    reset_n = 1;
    wait_ready;
    check(usb_release, 16'h0200);
    repeat (4) stim;
    // One short burst must still light the lamp, then let it go
    {tx_busy, rx_busy} = 2'b00;
    cyc(LAMP + 6);
    tx_busy = 1;
    cyc(1);
    tx_busy = 0;
    cyc(2);
    check(cfg_oe_n[0], 1'b0);
    for (int i = 0; i < LAMP + 8 && cfg_oe_n[0] !== 1'b1; i++) cyc(1);
    check(cfg_oe_n[0], 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      if (k == 0)
      begin
        sel = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h3};
        {pd, wk, inv} = {1'b1, 1'b1, 8'hff};
      end
      else
      begin
        for (int i = 0; i < 5; i++) sel[i] = 3'($urandom % 7);
        {pd, wk, inv} = 10'($urandom);
      end
      image = 0;
      for (int i = 0; i < 5; i++) image[i*3 +: 3] = sel[i];
      image[24:15] = {inv, wk, pd};
      image[40:25] = 16'h0200;
      blank = 0;
      usb_reset = 1;
      cyc(2);
      check(cfg_oe_n, 5'h1f);
      reads = 0;
      usb_reset = 0;
      wait_ready;
      repeat (4) stim;
    end
    finish_test;
  end
endmodule
